// File: include/mrs_defs.vh
`ifndef MRS_DEFS_VH
`define MRS_DEFS_VH

// Operation codes on opCode
`define MRS_OP_NOP      5'h00
`define MRS_OP_RETX     5'h01
`define MRS_OP_IRET     5'h02
`define MRS_OP_ROTL     5'h03
`define MRS_OP_ROTLF    5'h04
`define MRS_OP_ROTR     5'h05
`define MRS_OP_ROTRF    5'h06
`define MRS_OP_SUBB     5'h07
`define MRS_OP_SUB      5'h08
`define MRS_OP_SUBI     5'h09
`define MRS_OP_DECSK    5'h0a
`define MRS_OP_INCSK    5'h0b
`define MRS_OP_BITSK    5'h0c
`define MRS_OP_SETB     5'h0d
`define MRS_OP_SETBIT   5'h0e
`define MRS_OP_CALL     5'h0f

// Status flag positions in the flags bus
`define MRS_FLG_C       0
`define MRS_FLG_HC      1
`define MRS_FLG_Z       2
`define MRS_FLG_SW      3

// Reset values, and the all-ones byte written by set byte
`define MRS_RST_WREG    8'h00
`define MRS_RST_FLAGS   4'h0
`define MRS_RST_PC      12'h000
`define MRS_ALL_ONES    8'hff

// Cycles spent by skips and control transfers
`define MRS_LONG_CYCLES 2

`endif

// File: rtl/mrs_exec.v
`timescale 1ns/1ps
`include "mrs_defs.vh"

// Operation
// - Immediate return pops PC, loads immediate into register, keeps flags.
// - Interrupt return pops PC and sets master interrupt enable.
// - Pending interrupt after interrupt return is serviced before main code.
// - Rotate left moves bit 7 to bit 0; memory or register; no flags.
// - Rotate left through carry; old carry to bit 0, bit 7 to carry.
// - Rotate right moves bit 0 to bit 7; memory or register; no flags.
// - Rotate right through carry; old carry to bit 7, bit 0 to carry.
// - Subtract with borrow: register minus memory minus inverted carry.
// - Subtraction carry is zero on negative result, one otherwise.
// - Plain subtract of memory to register or memory, or of immediate to register only.
// - Decrement memory, write back, skip next when zero.
// - Decrement to register keeps memory, skips when result zero.
// - Increment memory, write back, skip next when zero.
// - Increment to register keeps memory, skips when result zero.
// - Bit test skips next instruction when selected bit is set.
// - Taken skip adds a dummy cycle; instruction takes two cycles.
// - Set byte writes all ones to memory, flags kept.
// - Set bit forces one selected bit high, others kept.
// - Call pushes PC plus one, then loads target address.
module mrs_exec #(
    parameter PC_WIDTH = 12
) (
    ref_clk,
    rst,
    opValid,
    opCode,
    toRegister,
    memData,
    immData,
    bitSel,
    targetAddr,
    stackTop,
    irqPending,
    busy,
    workingRegister,
    carryFlag,
    halfCarryFlag,
    zeroFlag,
    signedWrapFlag,
    masterIrqEnable,
    programCounter,
    memWrite,
    memWriteData,
    stackPush,
    stackPushData,
    stackPop,
    skipTaken,
    irqServiceReq,
    dummyCycle
);
    input  wire                ref_clk;
    input  wire                rst;
    input  wire                opValid;
    input  wire [4:0]          opCode;
    input  wire                toRegister;
    input  wire [7:0]          memData;
    input  wire [7:0]          immData;
    input  wire [2:0]          bitSel;
    input  wire [PC_WIDTH-1:0] targetAddr;
    input  wire [PC_WIDTH-1:0] stackTop;
    input  wire                irqPending;
    output reg                 busy;
    output reg  [7:0]          workingRegister;
    output reg                 carryFlag;
    output reg                 halfCarryFlag;
    output reg                 zeroFlag;
    output reg                 signedWrapFlag;
    output reg                 masterIrqEnable;
    output reg  [PC_WIDTH-1:0] programCounter;
    output reg                 memWrite;
    output reg  [7:0]          memWriteData;
    output reg                 stackPush;
    output reg  [PC_WIDTH-1:0] stackPushData;
    output reg                 stackPop;
    output reg                 skipTaken;
    output reg                 irqServiceReq;
    output reg                 dummyCycle;

    localparam ST_RUN   = 2'b01;
    localparam ST_DUMMY = 2'b10;

    reg  [1:0]          state;
    reg  [1:0]          next_state;
    reg  [7:0]          result;
    reg                 writeReg;
    reg                 writeMem;
    reg                 next_carry;
    reg                 arith;
    reg                 skip;
    reg                 jump;
    reg  [PC_WIDTH-1:0] jumpAddr;
    reg                 doPush;
    reg                 doPop;
    reg                 setIrqEn;
    reg  [7:0]          subB;
    reg                 subBorrow;
    wire [7:0]          subDiff;
    wire                subCarry;
    wire                subHalf;
    wire                subWrap;
    wire [7:0]          bitMask;
    wire                accept;

    assign accept  = opValid & (state == ST_RUN);
    assign bitMask = 8'h01 << bitSel;

    mrs_sub_unit uSub (
        .a          (workingRegister),
        .b          (subB),
        .borrowIn   (subBorrow),
        .diff       (subDiff),
        .carryOut   (subCarry),
        .halfCarry  (subHalf),
        .signedWrap (subWrap)
    );

    always @* begin
        result     = 8'h00;
        writeReg   = 1'b0;
        writeMem   = 1'b0;
        next_carry = carryFlag;
        arith      = 1'b0;
        skip       = 1'b0;
        jump       = 1'b0;
        jumpAddr   = stackTop;
        doPush     = 1'b0;
        doPop      = 1'b0;
        setIrqEn   = 1'b0;
        subB       = memData;
        subBorrow  = 1'b0;
        case (opCode)
            `MRS_OP_RETX: begin
                result   = immData;
                writeReg = 1'b1;
                jump     = 1'b1;
                doPop    = 1'b1;
            end
            `MRS_OP_IRET: begin
                jump     = 1'b1;
                doPop    = 1'b1;
                setIrqEn = 1'b1;
            end
            `MRS_OP_ROTL: begin
                result   = {memData[6:0], memData[7]};
                writeReg = toRegister;
                writeMem = ~toRegister;
            end
            `MRS_OP_ROTLF: begin
                result     = {memData[6:0], carryFlag};
                next_carry = memData[7];
                writeReg   = toRegister;
                writeMem   = ~toRegister;
            end
            `MRS_OP_ROTR: begin
                result   = {memData[0], memData[7:1]};
                writeReg = toRegister;
                writeMem = ~toRegister;
            end
            `MRS_OP_ROTRF: begin
                result     = {carryFlag, memData[7:1]};
                next_carry = memData[0];
                writeReg   = toRegister;
                writeMem   = ~toRegister;
            end
            `MRS_OP_SUBB: begin
                subBorrow  = ~carryFlag;
                result     = subDiff;
                next_carry = subCarry;
                arith      = 1'b1;
                writeReg   = toRegister;
                writeMem   = ~toRegister;
            end
            `MRS_OP_SUB: begin
                result     = subDiff;
                next_carry = subCarry;
                arith      = 1'b1;
                writeReg   = toRegister;
                writeMem   = ~toRegister;
            end
            `MRS_OP_SUBI: begin
                subB       = immData;
                result     = subDiff;
                next_carry = subCarry;
                arith      = 1'b1;
                writeReg   = 1'b1;
            end
            `MRS_OP_DECSK: begin
                result   = memData - 8'h01;
                writeReg = toRegister;
                writeMem = ~toRegister;
                skip     = (result == 8'h00);
            end
            `MRS_OP_INCSK: begin
                result   = memData + 8'h01;
                writeReg = toRegister;
                writeMem = ~toRegister;
                skip     = (result == 8'h00);
            end
            `MRS_OP_BITSK: begin
                skip = |(memData & bitMask);
            end
            `MRS_OP_SETB: begin
                result   = `MRS_ALL_ONES;
                writeMem = 1'b1;
            end
            `MRS_OP_SETBIT: begin
                result   = memData | bitMask;
                writeMem = 1'b1;
            end
            `MRS_OP_CALL: begin
                doPush   = 1'b1;
                jump     = 1'b1;
                jumpAddr = targetAddr;
            end
            default: begin
                result = 8'h00;
            end
        endcase
    end

    always @* begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (accept && (skip || jump)) begin
                    next_state = ST_DUMMY;
                end
            end
            ST_DUMMY: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            state           <= ST_RUN;
            busy            <= 1'b0;
            workingRegister <= `MRS_RST_WREG;
            carryFlag       <= 1'b0;
            halfCarryFlag   <= 1'b0;
            zeroFlag        <= 1'b0;
            signedWrapFlag  <= 1'b0;
            masterIrqEnable <= 1'b0;
            programCounter  <= `MRS_RST_PC;
            memWrite        <= 1'b0;
            memWriteData    <= 8'h00;
            stackPush       <= 1'b0;
            stackPushData   <= `MRS_RST_PC;
            stackPop        <= 1'b0;
            skipTaken       <= 1'b0;
            irqServiceReq   <= 1'b0;
            dummyCycle      <= 1'b0;
        end else begin
            state         <= next_state;
            busy          <= (next_state == ST_DUMMY);
            dummyCycle    <= (next_state == ST_DUMMY);
            memWrite      <= 1'b0;
            stackPush     <= 1'b0;
            stackPop      <= 1'b0;
            skipTaken     <= 1'b0;
            irqServiceReq <= 1'b0;
            if (accept) begin
                if (writeReg) begin
                    workingRegister <= result;
                end
                if (writeMem) begin
                    memWrite     <= 1'b1;
                    memWriteData <= result;
                end
                carryFlag <= next_carry;
                if (arith) begin
                    zeroFlag       <= (result == 8'h00);
                    halfCarryFlag  <= subHalf;
                    signedWrapFlag <= subWrap;
                end
                if (setIrqEn) begin
                    masterIrqEnable <= 1'b1;
                    irqServiceReq   <= irqPending;
                end
                stackPush     <= doPush;
                stackPop      <= doPop;
                stackPushData <= programCounter + {{(PC_WIDTH-1){1'b0}}, 1'b1};
                skipTaken     <= skip;
                if (jump) begin
                    programCounter <= jumpAddr;
                end else if (skip) begin
                    programCounter <= programCounter +
                                      {{(PC_WIDTH-2){1'b0}}, 2'b10};
                end else begin
                    programCounter <= programCounter +
                                      {{(PC_WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // mrs_exec

// File: rtl/mrs_sub_unit.v
`timescale 1ns/1ps
`include "mrs_defs.vh"

// Eight-bit subtract a - b - borrowIn, carry meaning "no borrow"
module mrs_sub_unit (
    a,
    b,
    borrowIn,
    diff,
    carryOut,
    halfCarry,
    signedWrap
);
    input  wire [7:0] a;
    input  wire [7:0] b;
    input  wire       borrowIn;
    output wire [7:0] diff;
    output wire       carryOut;
    output wire       halfCarry;
    output wire       signedWrap;

    wire [8:0] full;
    wire [4:0] low;

    assign full = {1'b0, a} - {1'b0, b} - {8'h00, borrowIn};
    assign low  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, borrowIn};
    assign diff = full[7:0];
    assign carryOut  = ~full[8];
    assign halfCarry = ~low[4];
    assign signedWrap = (a[7] ^ b[7]) & (a[7] ^ full[7]);
endmodule // mrs_sub_unit

// File: tb/mrs_exec_properties.sv
`timescale 1ns/1ps
`include "mrs_defs.vh"
module mrs_exec_properties #(
    parameter PC_WIDTH = 12
) (
    input wire                ref_clk,
    input wire                rst,
    input wire                opValid,
    input wire [4:0]          opCode,
    input wire                toRegister,
    input wire [7:0]          memData,
    input wire [7:0]          immData,
    input wire [PC_WIDTH-1:0] targetAddr,
    input wire [PC_WIDTH-1:0] stackTop,
    input wire                irqPending,
    input wire                busy,
    input wire [7:0]          workingRegister,
    input wire                carryFlag,
    input wire                masterIrqEnable,
    input wire [PC_WIDTH-1:0] programCounter,
    input wire                memWrite,
    input wire [7:0]          memWriteData,
    input wire                stackPush,
    input wire [PC_WIDTH-1:0] stackPushData,
    input wire                skipTaken,
    input wire                irqServiceReq
);
    wire take = opValid && !busy;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_skip_pc:
    assert property (skipTaken |-> busy &&
        programCounter == $past(programCounter) + 2'd2) else $error("skip");
    chk_dummy_once:
    assert property (busy |=> !busy) else $error("busy long");
    chk_iret_enable:
    assert property (take && opCode == `MRS_OP_IRET |=> masterIrqEnable &&
        programCounter == $past(stackTop)) else $error("iret");
    chk_iret_irq:
    assert property (take && opCode == `MRS_OP_IRET && irqPending
        |=> irqServiceReq) else $error("irq");
    chk_retx_load:
    assert property (take && opCode == `MRS_OP_RETX |=> workingRegister ==
        $past(immData) && $stable(carryFlag)) else $error("retx");
    chk_rotl_reg:
    assert property (take && opCode == `MRS_OP_ROTL && toRegister |=>
        workingRegister == {$past(memData[6:0]), $past(memData[7])}
        && !memWrite) else $error("rotl");
    chk_rotr_carry:
    assert property (take && opCode == `MRS_OP_ROTRF |=>
        carryFlag == $past(memData[0])) else $error("rotr carry");
    chk_setb_ones:
    assert property (take && opCode == `MRS_OP_SETB |=> memWrite &&
        memWriteData == `MRS_ALL_ONES) else $error("setb");
    chk_call_push:
    assert property (take && opCode == `MRS_OP_CALL |=> stackPush &&
        stackPushData == $past(programCounter) + 1'b1 &&
        programCounter == $past(targetAddr)) else $error("call");
    cover property (skipTaken);
    cover property (irqServiceReq);
    cover property (stackPush);
endmodule // mrs_exec_properties

bind mrs_exec mrs_exec_properties #(.PC_WIDTH(PC_WIDTH))
    i_mrs_exec_properties (
    .ref_clk(ref_clk), .rst(rst), .opValid(opValid), .opCode(opCode),
    .toRegister(toRegister), .memData(memData), .immData(immData),
    .targetAddr(targetAddr), .stackTop(stackTop), .irqPending(irqPending),
    .busy(busy), .workingRegister(workingRegister), .carryFlag(carryFlag),
    .masterIrqEnable(masterIrqEnable), .programCounter(programCounter),
    .memWrite(memWrite), .memWriteData(memWriteData),
    .stackPush(stackPush), .stackPushData(stackPushData),
    .skipTaken(skipTaken), .irqServiceReq(irqServiceReq));

// File: tb/mrs_exec_tb_top.sv
`timescale 1ns/1ps
`include "mrs_defs.vh"
module mrs_exec_tb_top;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        opValid = 1'b0;
    logic [4:0]  opCode = 5'h00;
    logic        toRegister = 1'b0;
    logic [7:0]  memData = 8'h00;
    logic [7:0]  immData = 8'h00;
    logic [2:0]  bitSel = 3'h0;
    logic [11:0] targetAddr = 12'h000;
    logic [11:0] stackTop = 12'h000;
    logic        irqPending = 1'b0;
    wire         busy, cy, hc, zf, wf, irqEn, memWrite, push, pop, skip;
    wire         irqReq, dummy;
    wire [7:0]   wr, memWd;
    wire [11:0]  pc, pushPc;
    wire [11:0]  regView = {wf, zf, hc, cy, wr};
    wire [11:0]  memView = {wf, zf, hc, cy, memWd};
    logic [11:0] prevPc;
    int          fail_count = 0;
    int          checks = 0;

    always #5 ref_clk = ~ref_clk;

    mrs_exec #(.PC_WIDTH(12)) i_mrs_exec (
        .ref_clk(ref_clk), .rst(rst), .opValid(opValid), .opCode(opCode),
        .toRegister(toRegister), .memData(memData), .immData(immData),
        .bitSel(bitSel), .targetAddr(targetAddr), .stackTop(stackTop),
        .irqPending(irqPending), .busy(busy), .workingRegister(wr),
        .carryFlag(cy), .halfCarryFlag(hc), .zeroFlag(zf),
        .signedWrapFlag(wf), .masterIrqEnable(irqEn), .programCounter(pc),
        .memWrite(memWrite), .memWriteData(memWd), .stackPush(push),
        .stackPushData(pushPc), .stackPop(pop), .skipTaken(skip),
        .irqServiceReq(irqReq), .dummyCycle(dummy));

    task chk(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            fail_count++;
        end
    endtask

    task close_out;
        if (fail_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Fields: overflow, zero, half carry, carry (no borrow), result
    function automatic logic [11:0] sub_ref(input logic [7:0] a, b,
                                            input logic c);
        logic [8:0] d;
        logic       h;
        d = {1'b0, a} - {1'b0, b} - {8'h00, !c};
        h = {1'b0, a[3:0]} >= {1'b0, b[3:0]} + {4'h0, !c};
        return {(a[7] ^ b[7]) & (d[7] ^ a[7]), d[7:0] == 8'h00, h, !d[8],
                d[7:0]};
    endfunction

    // One accepted operation; outputs are settled when this returns
    task op(input logic [4:0] c, input logic r, input logic [7:0] m,
            input logic [7:0] i, input logic [2:0] b);
        @(posedge ref_clk);
        opValid <= 1'b1;
        opCode <= c;
        toRegister <= r;
        memData <= m;
        immData <= i;
        bitSel <= b;
        #1 prevPc = pc;
        @(posedge ref_clk);
        opValid <= 1'b0;
        #1;
    endtask

    task t_sub;
        @(posedge ref_clk) stackTop <= 12'h123;
        op(`MRS_OP_RETX, 1'b1, 8'h00, 8'h80, 3'h0);
        chk({busy, pop, pc, wr, cy}, {2'b11, 12'h123, 8'h80, 1'b0});
        op(`MRS_OP_SUBI, 1'b1, 8'h00, 8'h01, 3'h0);
        chk(regView, sub_ref(8'h80, 8'h01, 1'b1));
        chk(pc, prevPc + 12'h001);
        op(`MRS_OP_SUBB, 1'b1, 8'h7f, 8'h00, 3'h0);
        chk(regView, sub_ref(8'h7f, 8'h7f, 1'b1));
        op(`MRS_OP_SUB, 1'b0, 8'h01, 8'h00, 3'h0);
        chk({memWrite, wr}, 9'h100);
        chk(memView, sub_ref(8'h00, 8'h01, 1'b1));
        op(`MRS_OP_SUBB, 1'b1, 8'h00, 8'h00, 3'h0);
        chk(regView, sub_ref(8'h00, 8'h00, 1'b0));
    endtask

    task t_rot;
        op(`MRS_OP_ROTLF, 1'b1, 8'h81, 8'h00, 3'h0);
        chk({memWrite, cy, wr}, {2'b01, 8'h02});
        op(`MRS_OP_ROTRF, 1'b0, 8'h02, 8'h00, 3'h0);
        chk({memWrite, cy, memWd, wr}, {2'b10, 8'h81, 8'h02});
        op(`MRS_OP_ROTL, 1'b0, 8'h81, 8'h00, 3'h0);
        chk({memWrite, cy, memWd, wr}, {2'b10, 8'h03, 8'h02});
        op(`MRS_OP_ROTR, 1'b1, 8'h01, 8'h00, 3'h0);
        chk({memWrite, cy, wr}, {2'b00, 8'h80});
    endtask

    task t_skip;
        op(`MRS_OP_DECSK, 1'b0, 8'h01, 8'h00, 3'h0);
        chk({memWrite, memWd, skip, busy, dummy}, {9'h100, 3'h7});
        chk(pc, prevPc + 12'h002);
        op(`MRS_OP_DECSK, 1'b1, 8'h05, 8'h00, 3'h0);
        chk({memWrite, wr, skip, busy}, {9'h004, 2'b00});
        chk(pc, prevPc + 12'h001);
        op(`MRS_OP_INCSK, 1'b1, 8'hff, 8'h00, 3'h0);
        chk({memWrite, wr, skip, busy}, {9'h000, 2'b11});
        chk(pc, prevPc + 12'h002);
        op(`MRS_OP_INCSK, 1'b0, 8'h10, 8'h00, 3'h0);
        chk({memWrite, memWd, skip, busy}, {9'h111, 2'b00});
        op(`MRS_OP_BITSK, 1'b0, 8'h08, 8'h00, 3'h3);
        chk({memWrite, skip, pc}, {2'b01, prevPc + 12'h002});
        op(`MRS_OP_BITSK, 1'b0, 8'hf7, 8'h00, 3'h3);
        chk({memWrite, skip, pc}, {2'b00, prevPc + 12'h001});
    endtask

    task t_set;
        op(`MRS_OP_SETB, 1'b0, 8'h12, 8'h00, 3'h0);
        chk({memWrite, memWd, cy}, {1'b1, `MRS_ALL_ONES, 1'b0});
        op(`MRS_OP_SETBIT, 1'b0, 8'h10, 8'h00, 3'h7);
        chk({memWrite, memWd, cy}, {9'h190, 1'b0});
    endtask

    task t_ctrl;
        @(posedge ref_clk);
        targetAddr <= 12'h456;
        stackTop <= 12'h3a0;
        irqPending <= 1'b1;
        op(`MRS_OP_CALL, 1'b0, 8'h00, 8'h00, 3'h0);
        chk({push, pushPc, busy}, {1'b1, prevPc + 12'h001, 1'b1});
        chk(pc, 12'h456);
        op(`MRS_OP_IRET, 1'b0, 8'h00, 8'h00, 3'h0);
        chk({pop, irqEn, irqReq, pc, cy}, {3'h7, 12'h3a0, 1'b0});
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        #1 chk({busy, wr, pc, cy, irqEn, memWrite}, 24'h000000);
        t_sub;
        t_rot;
        t_skip;
        t_set;
        t_ctrl;
        close_out;
    end

    initial begin
        #200000;
        fail_count++;
        close_out;
    end
endmodule // mrs_exec_tb_top
